// ---- verilog/cspm_top.sv ----
// Comms slave memory map: slave register bank and queue area placement.
//
// Overview of operation
// - Decode slave range under base with sampled ID.
// - Unmapped slave addresses never get an answer.
// - Read-only ID word of four packed fields.
// - Queue base is masked register shifted four.
// - Queue length is one shifted by low bits.
// - Reply, thread, DMA queues back to back.
// - Six 16-byte exception areas below queue base.
// - Queue items are aligned 32-byte entries.
// - Queue checks give only full or memory fault.
// - Seconds and nanoseconds words individually read/writable.
// - Read-only double word returns seconds then nanoseconds.
// - Double word placement independent of byte order.
// - Alarm is a read/write down counter.
// - 256K command window, 63 pages, page zero info.
// - Single 4K hush area, readable and writable.
// - Interrupt register is read-only word.
// - Host interrupt mask is a stored word.
// - 32 event vector entries of word pairs.
// - Double reads of single registers repeat value.
`timescale 1ns/1ps
`default_nettype none
module cspm_top import cspm_pkg::*; #(
  parameter int          HUSH_WORDS = 1024,
  parameter int          ALARM_DIV  = 250,
  parameter logic [15:0] ID_IMPL    = 16'h0000, // Arbitrary value.
  parameter logic [7:0]  ID_TYPE    = 8'h5A,    // Arbitrary value.
  parameter logic [3:0]  ID_REV     = 4'h1,     // Arbitrary value.
  parameter logic [3:0]  ID_VENDOR  = 4'h3      // Arbitrary value.
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // Bus identifier pins
  input  wire logic [3:0]  busid_i,
  // Slave access port
  input  wire logic        mb_req_i,
  input  wire cspm_req_s   mb_cmd_i,
  output logic             mb_ack_o,
  output logic      [63:0] mb_rdata_o,
  // Interrupts and control
  input  wire logic [31:0] irq_src_i,
  output logic             host_irq_o,
  output logic      [15:0] control_o,
  output logic             alarm_zero_o,
  // Command port
  output logic             cmd_valid_o,
  output logic      [5:0]  cmd_page_o,
  output logic      [31:0] cmd_data_o,
  // Queue area configuration and access
  input  wire logic [31:0] qab_i,
  input  wire logic [35:0] ev_base_i,
  input  wire logic [1:0]  q_sel_i,
  input  wire logic [2:0]  x_sel_i,
  input  wire logic [4:0]  ev_idx_i,
  input  wire logic        q_op_i,
  input  wire logic        q_ctx_zero_i,
  input  wire logic [31:0] q_slot_i,
  input  wire logic        q_mem_err_i,
  output logic      [35:0] q_store_base_o,
  output logic      [31:0] q_size_o,
  output logic      [35:0] q_start_o,
  output logic      [35:0] x_start_o,
  output logic      [35:0] ev_addr_o,
  output logic             q_done_o,
  output logic      [35:0] q_item_addr_o,
  output cspm_qfault_e     q_fault_o
);
  localparam int HUSH_AW = $clog2(HUSH_WORDS);
  localparam int NS_STEP = CLK_PERIOD_NS;
  localparam int ADIV_W  = $clog2(ALARM_DIV + 1);

  if (HUSH_WORDS < 2 || HUSH_WORDS > 1024 || (1 << HUSH_AW) != HUSH_WORDS) begin : g_chk_hush
    $error("HUSH_WORDS must be a power of two from 2 to 1024");
  end
  if (ALARM_DIV < 1) begin : g_chk_div
    $error("ALARM_DIV must be at least one");
  end

  // Identifier pins are static straps but still pass a three-stage synchroniser.
  logic [3:0] id_s1, id_s2, id_s3, busid;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      id_s1 <= 4'h0;
      id_s2 <= 4'h0;
      id_s3 <= 4'h0;
      busid <= 4'h0;
    end else begin
      id_s1 <= busid_i;
      id_s2 <= id_s1;
      id_s3 <= id_s2;
      busid <= (id_s2 == id_s3) ? id_s3 : busid;
    end
  end

  // Address decode.
  wire logic [23:0] off      = mb_cmd_i.addr[OFF_W-1:0];
  wire logic        in_range = mb_cmd_i.addr[35:28] == BASE_HI && mb_cmd_i.addr[27:24] == busid;
  wire logic        wr       = mb_cmd_i.we && !mb_cmd_i.dw;
  wire logic        hit_hush = off[23:PAGE_LSB] == OFF_HUSH[23:PAGE_LSB];
  wire logic        hit_cmd  = off[23:CMD_LSB] == OFF_CMD[23:CMD_LSB];
  wire logic [5:0]  page     = off[CMD_LSB-1:PAGE_LSB];
  wire logic [31:0] ident    = {ID_IMPL, ID_TYPE, ID_REV, ID_VENDOR};

  logic [31:0] ctrl, mask, pend, alarm, secs, nsec;
  logic [ADIV_W-1:0] adiv;
  logic [31:0] hush [HUSH_WORDS];
  logic [5:0]  last_page;

  // Word value and map hit for an aligned offset; aliases give the same word.
  logic        hit_w;
  logic [31:0] rword;
  always_comb begin
    hit_w = 1'b1;
    unique case ({off[23:2], 2'b00})
      OFF_ID, OFF_ID_A:     rword = ident;
      OFF_CTRL, OFF_CTRL_A: rword = {16'h0000, ctrl[CTRL_W-1:0]};
      OFF_MASK, OFF_MASK_A: rword = mask;
      OFF_INT, OFF_INT_A:   rword = pend;
      OFF_ALRM, OFF_ALRM_A: rword = alarm;
      OFF_NS, OFF_NS_A:     rword = nsec;
      OFF_SEC, OFF_SEC_A:   rword = secs;
      OFF_CLKDW:            rword = secs;
      default: begin
        hit_w = 1'b0;
        rword = 32'h0;
      end
    endcase
  end

  // Double words sit on 8-byte offsets; all are read-only copies.
  wire logic [23:0] dw_off   = {off[23:3], 3'b000};
  wire logic        hit_dw   = hit_w && off[2] == 1'b0;
  // The first word is the high half regardless of the master's byte order.
  wire logic [63:0] rdouble  = (dw_off == OFF_CLKDW) ? {secs, nsec} : {rword, rword};
  wire logic [HUSH_AW-1:0] hidx = off[HUSH_AW+1:2];
  wire logic        mapped   = in_range && (mb_cmd_i.dw ? hit_dw : (hit_w || hit_hush || hit_cmd));
  wire logic        take     = mb_req_i && mapped;

  // Writes reach only the read/write words; alias and read-only offsets drop them.
  wire logic wr_ctrl  = take && wr && off == OFF_CTRL;
  wire logic wr_mask  = take && wr && off == OFF_MASK;
  wire logic wr_alarm = take && wr && off == OFF_ALRM;
  wire logic wr_secs  = take && wr && off == OFF_SEC;
  wire logic wr_nsec  = take && wr && off == OFF_NS;
  wire logic wr_hush  = take && wr && hit_hush;
  wire logic wr_cmd   = take && wr && hit_cmd && page != 6'h00;

  // Time of day advances by the clock period each cycle.
  wire logic [31:0] ns_inc   = nsec + 32'(NS_STEP);
  wire logic        ns_wrap  = ns_inc >= NS_PER_SEC;
  wire logic [31:0] next_ns  = wr_nsec ? mb_cmd_i.wdata : (ns_wrap ? ns_inc - NS_PER_SEC : ns_inc);
  wire logic [31:0] next_sec = wr_secs ? mb_cmd_i.wdata : (ns_wrap ? secs + 32'h1 : secs);
  wire logic        atick    = adiv == ADIV_W'(ALARM_DIV - 1);
  wire logic [31:0] next_alm = wr_alarm ? mb_cmd_i.wdata :
                               (atick && alarm != 32'h0) ? alarm - 32'h1 : alarm;

  logic [63:0] next_rd;
  always_comb begin
    if (mb_cmd_i.dw) begin
      next_rd = rdouble;
    end else if (hit_hush) begin
      next_rd = {32'h0, hush[hidx]};
    end else if (hit_cmd) begin
      next_rd = {32'h0, (page == 6'h00) ? {26'h0, last_page} : 32'h0};
    end else begin
      next_rd = {32'h0, rword};
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl  <= 32'h0;
      mask  <= 32'h0;
      pend  <= 32'h0;
      alarm <= 32'h0;
      adiv  <= '0;
      secs  <= 32'h0;
      nsec  <= 32'h0;
    end else begin
      ctrl  <= wr_ctrl ? {16'h0000, mb_cmd_i.wdata[CTRL_W-1:0]} : ctrl;
      mask  <= wr_mask ? mb_cmd_i.wdata : mask;
      pend  <= irq_src_i;
      alarm <= next_alm;
      adiv  <= atick ? '0 : adiv + ADIV_W'(1);
      secs  <= next_sec;
      nsec  <= next_ns;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mb_ack_o    <= 1'b0;
      mb_rdata_o  <= 64'h0;
      cmd_valid_o <= 1'b0;
      cmd_page_o  <= 6'h00;
      cmd_data_o  <= 32'h0;
      last_page   <= 6'h00;
      host_irq_o  <= 1'b0;
    end else begin
      mb_ack_o    <= take;
      mb_rdata_o  <= take ? next_rd : mb_rdata_o;
      cmd_valid_o <= wr_cmd;
      cmd_page_o  <= wr_cmd ? page : cmd_page_o;
      cmd_data_o  <= wr_cmd ? mb_cmd_i.wdata : cmd_data_o;
      last_page   <= wr_cmd ? page : last_page;
      host_irq_o  <= |(pend & mask);
    end
  end

  // Hush store has no reset so that it maps onto a plain RAM.
  always_ff @(posedge mclk_i) begin
    if (wr_hush) begin
      hush[hidx] <= mb_cmd_i.wdata;
    end
  end

  assign control_o    = ctrl[CTRL_W-1:0];
  assign alarm_zero_o = alarm == 32'h0;

  cspm_qmap u_qmap (
    .mclk_i         (mclk_i),
    .rstn_i         (rstn_i),
    .qab_i          (qab_i),
    .ev_base_i      (ev_base_i),
    .q_sel_i        (q_sel_i),
    .x_sel_i        (x_sel_i),
    .ev_idx_i       (ev_idx_i),
    .q_store_base_o (q_store_base_o),
    .q_size_o       (q_size_o),
    .q_start_o      (q_start_o),
    .x_start_o      (x_start_o),
    .ev_addr_o      (ev_addr_o)
  );

  cspm_qchk u_qchk (
    .mclk_i      (mclk_i),
    .rstn_i      (rstn_i),
    .op_i        (q_op_i),
    .ctx_zero_i  (q_ctx_zero_i),
    .slot_i      (q_slot_i),
    .q_size_i    (q_size_o),
    .q_start_i   (q_start_o),
    .mem_err_i   (q_mem_err_i),
    .done_o      (q_done_o),
    .item_addr_o (q_item_addr_o),
    .fault_o     (q_fault_o)
  );

  // Checks.
  a_unmapped_silent: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    mb_req_i && !in_range |=> !mb_ack_o) else $error("Ack given outside slave range");
  a_id_readback: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    take && !mb_cmd_i.dw && off == OFF_ID |=> mb_rdata_o[31:0] == ident) else $error("ID word wrong");
  a_qbase_shift: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $stable(qab_i) |=> q_store_base_o == {$past(qab_i[31:5]), 9'h000}) else $error("Queue base wrong");
  a_qsize_pow: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    1'b1 |=> q_size_o == (32'h1 << $past(qab_i[4:0]))) else $error("Queue size wrong");
  a_item_align: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    q_done_o |-> q_item_addr_o[4:0] == q_start_o[4:0] || $changed(q_start_o)) else $error("Item misaligned");
  a_clock_dword: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    take && mb_cmd_i.dw && off == OFF_CLKDW |=> mb_rdata_o == {$past(secs), $past(nsec)})
    else $error("Clock double word wrong");
  a_dword_twice: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    mb_ack_o && $past(mb_cmd_i.dw) && $past(off) != OFF_CLKDW |-> mb_rdata_o[63:32] == mb_rdata_o[31:0])
    else $error("Double word halves differ");
  a_ro_ignored: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    take && mb_cmd_i.we && off == OFF_MASK_A |=> mb_ack_o && $stable(mask)) else $error("Alias write took");
  a_alarm_down: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    atick && alarm != 32'h0 && !wr_alarm |=> alarm == $past(alarm) - 32'h1) else $error("Alarm not counting");
  a_mask_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    mask == 32'h0 ##1 mask == 32'h0 |-> !host_irq_o) else $error("Masked interrupt raised");
  c_hush_write: cover property (@(posedge mclk_i) disable iff (!rstn_i) wr_hush ##1 mb_ack_o);
  c_cmd_post: cover property (@(posedge mclk_i) disable iff (!rstn_i) cmd_valid_o);
  c_clock_read: cover property (@(posedge mclk_i) disable iff (!rstn_i) take && mb_cmd_i.dw && off == OFF_CLKDW);
  c_queue_full: cover property (@(posedge mclk_i) disable iff (!rstn_i) q_fault_o == CSPM_Q_FULL);
endmodule : cspm_top
`default_nettype wire

// ---- verilog/cspm_pkg.sv ----
// Shared constants and types for the comms slave memory map.
`default_nettype none
package cspm_pkg;
  localparam int          ADDR_W     = 36;
  localparam logic [7:0]  BASE_HI    = 8'hFF;
  localparam int          BUSID_W    = 4;
  localparam int          OFF_W      = 24;
  // Slave word offsets below the bus base; the A entries are read-only aliases.
  localparam logic [23:0] OFF_ID     = 24'hFFFFFC;
  localparam logic [23:0] OFF_ID_A   = 24'hFFFFF8;
  localparam logic [23:0] OFF_CTRL_A = 24'hFFFFF4;
  localparam logic [23:0] OFF_CTRL   = 24'hFFFFF0;
  localparam logic [23:0] OFF_MASK_A = 24'hFFFFEC;
  localparam logic [23:0] OFF_MASK   = 24'hFFFFE8;
  localparam logic [23:0] OFF_CLKDW  = 24'hFFFFE0;
  localparam logic [23:0] OFF_INT_A  = 24'hFFFFDC;
  localparam logic [23:0] OFF_INT    = 24'hFFFFD8;
  localparam logic [23:0] OFF_ALRM_A = 24'hFFFFD4;
  localparam logic [23:0] OFF_ALRM   = 24'hFFFFD0;
  localparam logic [23:0] OFF_NS_A   = 24'hFFFFCC;
  localparam logic [23:0] OFF_NS     = 24'hFFFFC8;
  localparam logic [23:0] OFF_SEC_A  = 24'hFFFFC4;
  localparam logic [23:0] OFF_SEC    = 24'hFFFFC0;
  localparam logic [23:0] OFF_HUSH   = 24'hFFE000;
  localparam logic [23:0] OFF_CMD    = 24'hF80000;
  localparam int          PAGE_LSB   = 12;
  localparam int          CMD_LSB    = 18;
  localparam int          CTRL_W     = 16;
  // Queue area layout.
  localparam int          QB_LSB     = 5;
  localparam int          QB_SHIFT   = 4;
  localparam int          QITEM_LG   = 5;
  localparam int          XAREA_LG   = 4;
  localparam int          NUM_Q      = 3;
  localparam int          NUM_X      = 6;
  localparam int          EV_ENTRIES = 32;
  localparam int          EV_LG      = 3;
  // Time of day.
  localparam int          CLK_PERIOD_NS = 4;
  localparam logic [31:0] NS_PER_SEC    = 32'h3B9ACA00;
  typedef struct packed {
    logic [35:0] addr;
    logic        we;
    logic        dw;
    logic [31:0] wdata;
  } cspm_req_s;
  typedef enum logic [1:0] {CSPM_Q_OK, CSPM_Q_FULL, CSPM_Q_MEMERR} cspm_qfault_e;
endpackage : cspm_pkg
`default_nettype wire

// ---- verilog/cspm_qmap.sv ----
// Queue area, exception area and event vector address generator.
`timescale 1ns/1ps
`default_nettype none
module cspm_qmap import cspm_pkg::*; (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // Configuration
  input  wire logic [31:0] qab_i,
  input  wire logic [35:0] ev_base_i,
  // Selects
  input  wire logic [1:0]  q_sel_i,
  input  wire logic [2:0]  x_sel_i,
  input  wire logic [4:0]  ev_idx_i,
  // Results
  output logic      [35:0] q_store_base_o,
  output logic      [31:0] q_size_o,
  output logic      [35:0] q_start_o,
  output logic      [35:0] x_start_o,
  output logic      [35:0] ev_addr_o
);
  wire logic [35:0] next_base = {qab_i[31:QB_LSB], {QB_LSB{1'b0}}, {QB_SHIFT{1'b0}}};
  wire logic [4:0]  lg_size   = qab_i[QB_LSB-1:0];
  wire logic [31:0] next_size = 32'h1 << lg_size;
  // The span of one queue is its size in 32-byte items.
  wire logic [35:0] span      = 36'h1 << (6'(lg_size) + 6'(QITEM_LG));
  wire logic [35:0] next_q    = next_base + 36'(q_sel_i) * span;
  wire logic [35:0] next_x    = next_base - (36'(x_sel_i) + 36'h1) * (36'h1 << XAREA_LG);
  wire logic [35:0] next_ev   = ev_base_i + (36'(ev_idx_i) << EV_LG);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_store_base_o <= 36'h0;
      q_size_o       <= 32'h0;
      q_start_o      <= 36'h0;
      x_start_o      <= 36'h0;
      ev_addr_o      <= 36'h0;
    end else begin
      q_store_base_o <= next_base;
      q_size_o       <= next_size;
      q_start_o      <= next_q;
      x_start_o      <= next_x;
      ev_addr_o      <= next_ev;
    end
  end
endmodule : cspm_qmap
`default_nettype wire

// ---- verilog/cspm_qchk.sv ----
// Queue operation checker: item address and fault classification.
`timescale 1ns/1ps
`default_nettype none
module cspm_qchk import cspm_pkg::*; (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  // Operation
  input  wire logic         op_i,
  input  wire logic         ctx_zero_i,
  input  wire logic [31:0]  slot_i,
  input  wire logic [31:0]  q_size_i,
  input  wire logic [35:0]  q_start_i,
  input  wire logic         mem_err_i,
  // Result
  output logic              done_o,
  output logic [35:0]       item_addr_o,
  output cspm_qfault_e      fault_o
);
  // Context zero keeps one slot in reserve so that it can never fill the queue.
  wire logic ovf     = slot_i >= q_size_i;
  wire logic ctx_ovf = ctx_zero_i && (slot_i >= q_size_i - 32'h1);
  wire cspm_qfault_e next_fault = (ovf || ctx_ovf) ? CSPM_Q_FULL :
                                  mem_err_i ? CSPM_Q_MEMERR : CSPM_Q_OK;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o      <= 1'b0;
      item_addr_o <= 36'h0;
      fault_o     <= CSPM_Q_OK;
    end else begin
      done_o      <= op_i;
      item_addr_o <= q_start_i + (36'(slot_i) << QITEM_LG);
      fault_o     <= op_i ? next_fault : CSPM_Q_OK;
    end
  end
endmodule : cspm_qchk
`default_nettype wire

// ---- verification/cspm_host_model.sv ----
// Behavioural bus master that issues single slave accesses to the register bank.
`timescale 1ns/1ps
`default_nettype none
module cspm_host_model import cspm_pkg::*; (
  // Clock
  input  wire logic        mclk_i,
  // Slave access port
  output var logic         mb_req_o,
  output var cspm_req_s    mb_cmd_o,
  input  wire logic        mb_ack_i,
  input  wire logic [63:0] mb_rdata_i
);
  initial begin
    mb_req_o = 1'b0;
    mb_cmd_o = '0;
  end
  // The command is inverted once released, so a late sample by the slave cannot match by luck.
  task automatic access(input logic [3:0] id, input logic [23:0] off, input logic we, input logic dw,
                        input logic [31:0] wd, output logic acked, output logic [63:0] rd);
    acked = 1'b0;
    rd    = '0;
    @(posedge mclk_i);
    mb_req_o <= 1'b1;
    mb_cmd_o <= '{addr: {BASE_HI, id, off}, we: we, dw: dw, wdata: wd};
    @(posedge mclk_i);
    mb_req_o <= 1'b0;
    mb_cmd_o <= ~mb_cmd_o;
    // Unmapped accesses are never answered, so the wait is bounded like a bus timeout.
    repeat (6) begin
      @(negedge mclk_i);
      if (!acked && mb_ack_i === 1'b1) begin
        acked = 1'b1;
        rd    = mb_rdata_i;
      end
    end
  endtask : access
endmodule : cspm_host_model
`default_nettype wire

// ---- verification/comms_slave_memory_map_tb.sv ----
// Self-checking testbench for the comms slave memory map.
`timescale 1ns/1ps
`default_nettype none
module comms_slave_memory_map_tb import cspm_pkg::*;;
  localparam logic [31:0] ID_WORD = 32'h12345A13; // Arbitrary identification value.
  localparam logic [3:0]  BUS_ID  = 4'hA;
  logic mclk_i, rstn_i, mb_req_i, mb_ack_o, host_irq_o, alarm_zero_o, cmd_valid_o;
  logic q_op_i, q_ctx_zero_i, q_mem_err_i, q_done_o, acked;
  cspm_req_s    mb_cmd_i;
  cspm_qfault_e q_fault_o;
  logic [3:0]   busid_i;
  logic [63:0]  mb_rdata_o, rd_data;
  logic [31:0]  irq_src_i, qab_i, q_slot_i, q_size_o, cmd_data_o, seed = 32'h3E64;
  logic [15:0]  control_o;
  logic [5:0]   cmd_page_o;
  logic [35:0]  ev_base_i, q_store_base_o, q_start_o, x_start_o, ev_addr_o, q_item_addr_o;
  logic [1:0]   q_sel_i;
  logic [2:0]   x_sel_i;
  logic [4:0]   ev_idx_i;
  logic [127:0] exp_q[$], e;
  logic [37:0]  qop_q[$], f;
  int           fail_count = 0, samples_checked = 0, cmd_pulses = 0;

  cspm_top #(.HUSH_WORDS(16), .ALARM_DIV(2), .ID_IMPL(ID_WORD[31:16]), .ID_TYPE(ID_WORD[15:8]),
             .ID_REV(ID_WORD[7:4]), .ID_VENDOR(ID_WORD[3:0])) uut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .busid_i(busid_i), .mb_req_i(mb_req_i), .mb_cmd_i(mb_cmd_i),
    .mb_ack_o(mb_ack_o), .mb_rdata_o(mb_rdata_o), .irq_src_i(irq_src_i), .host_irq_o(host_irq_o),
    .control_o(control_o), .alarm_zero_o(alarm_zero_o), .cmd_valid_o(cmd_valid_o), .cmd_page_o(cmd_page_o),
    .cmd_data_o(cmd_data_o), .qab_i(qab_i), .ev_base_i(ev_base_i), .q_sel_i(q_sel_i), .x_sel_i(x_sel_i),
    .ev_idx_i(ev_idx_i), .q_op_i(q_op_i), .q_ctx_zero_i(q_ctx_zero_i), .q_slot_i(q_slot_i),
    .q_mem_err_i(q_mem_err_i), .q_store_base_o(q_store_base_o), .q_size_o(q_size_o), .q_start_o(q_start_o),
    .x_start_o(x_start_o), .ev_addr_o(ev_addr_o), .q_done_o(q_done_o), .q_item_addr_o(q_item_addr_o),
    .q_fault_o(q_fault_o));

  cspm_host_model host (.mclk_i(mclk_i), .mb_req_o(mb_req_i), .mb_cmd_o(mb_cmd_i), .mb_ack_i(mb_ack_o),
                        .mb_rdata_i(mb_rdata_o));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic acc(input logic [3:0] id, input logic [23:0] off, input logic we, input logic dw,
                     input logic [31:0] wd, input logic [63:0] exp, input logic [63:0] mask, input logic want);
    if (want) exp_q.push_back({mask, exp});
    host.access(id, off, we, dw, wd, acked, rd_data);
    chk("ack", acked, want);
  endtask : acc

  task automatic wr(input logic [23:0] off, input logic [31:0] d);
    acc(BUS_ID, off, 1'b1, 1'b0, d, '0, '0, 1'b1);
  endtask : wr

  task automatic rd(input logic [23:0] off, input logic dw, input logic [63:0] exp, input logic [63:0] mask = '1);
    acc(BUS_ID, off, 1'b0, dw, '0, exp, mask, 1'b1);
  endtask : rd

  // Every answer is matched against the oldest expectation noted by the driver.
  always @(negedge mclk_i) begin
    if (cmd_valid_o === 1'b1) cmd_pulses++;
    if (mb_ack_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spare_ack", 1'b1, 1'b0);
      end else begin
        e = exp_q.pop_front();
        chk("rdata", mb_rdata_o & e[127:64], e[63:0]);
      end
    end
    if (q_done_o === 1'b1 && qop_q.size() > 0) begin
      f = qop_q.pop_front();
      chk("q_fault", q_fault_o, f[37:36]);
      if (f[37:36] == CSPM_Q_OK) chk("q_item", q_item_addr_o, f[35:0]);
    end
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    wrap_up();
  end

  initial begin
    logic [31:0] v, m, s, q, sz, hv[4], slots[5];
    logic [35:0] qb, st;
    cspm_qfault_e faults[5];
    int n;
    rstn_i = 1'b0; busid_i = BUS_ID; irq_src_i = '0; qab_i = 32'h45; ev_base_i = 36'h0_0001_0000;
    q_sel_i = '0; x_sel_i = '0; ev_idx_i = '0; q_op_i = 1'b0; q_ctx_zero_i = 1'b0; q_slot_i = '0;
    q_mem_err_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rd(OFF_ID, 1'b0, {32'h0, ID_WORD});
    rd(OFF_ID_A, 1'b1, {ID_WORD, ID_WORD});
    wr(OFF_ID, ~ID_WORD);
    rd(OFF_ID, 1'b0, {32'h0, ID_WORD});
    acc(BUS_ID, 24'hFFFFE4, 1'b0, 1'b0, '0, '0, '0, 1'b0);
    acc(BUS_ID ^ 4'h5, OFF_ID, 1'b0, 1'b0, '0, '0, '0, 1'b0);
    acc(BUS_ID, OFF_HUSH, 1'b0, 1'b1, '0, '0, '0, 1'b0);
    acc(BUS_ID, OFF_CMD, 1'b0, 1'b1, '0, '0, '0, 1'b0);
    v = rnd();
    wr(OFF_CTRL, v);
    rd(OFF_CTRL_A, 1'b0, {48'h0, v[15:0]});
    chk("control", control_o, v[15:0]);
    m = rnd();
    wr(OFF_MASK, m);
    wr(OFF_MASK_A, ~m);
    rd(OFF_MASK, 1'b1, {m, m});
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i);
      irq_src_i <= k ? (rnd() | m) : (rnd() & ~m);
      repeat (3) @(posedge mclk_i);
      wr(OFF_INT, ~irq_src_i);
      rd(OFF_INT, 1'b1, {irq_src_i, irq_src_i});
      chk("host_irq", host_irq_o, |(irq_src_i & m));
    end
    s = rnd();
    wr(OFF_SEC, s);
    wr(OFF_NS, 32'h100);
    wr(OFF_SEC_A, ~s);
    rd(OFF_SEC, 1'b1, {s, s});
    rd(OFF_CLKDW, 1'b1, {s, 32'h0}, {32'hFFFFFFFF, 32'h0});
    chk("ns_low", (rd_data[31:0] > 32'h100) && (rd_data[31:0] < 32'h300), 1'b1);
    rd(OFF_NS, 1'b1, '0, '0);
    chk("ns_pair", rd_data[63:32], rd_data[31:0]);
    wr(OFF_ALRM, 32'h5);
    repeat (30) @(posedge mclk_i);
    rd(OFF_ALRM_A, 1'b0, '0);
    chk("alarm_zero", alarm_zero_o, 1'b1);
    wr(OFF_ALRM, 32'hFFFF);
    rd(OFF_ALRM, 1'b0, '0, '0);
    chk("alarm_run", (rd_data[31:0] < 32'hFFFF) && (rd_data[31:0] > 32'hFFE0), 1'b1);
    chk("alarm_nz", alarm_zero_o, 1'b0);
    foreach (hv[i]) begin
      hv[i] = rnd();
      wr(OFF_HUSH + 24'(4 * i), hv[i]);
    end
    foreach (hv[i]) rd(OFF_HUSH + 24'(4 * i), 1'b0, {32'h0, hv[i]});
    n = cmd_pulses;
    v = rnd();
    wr(OFF_CMD | 24'h25000, v);
    chk("cmd_page", cmd_page_o, 6'h25);
    chk("cmd_data", cmd_data_o, v);
    chk("cmd_one", cmd_pulses - n, 1);
    wr(OFF_CMD, rnd());
    chk("cmd_pulses", cmd_pulses - n, 1);
    rd(OFF_CMD, 1'b0, {58'h0, 6'h25});
    rd(OFF_CMD | 24'h5000, 1'b0, '0);
    for (int k = 0; k < 2; k++) begin
      q = rnd();
      for (int i = 0; i < 6; i++) begin
        @(posedge mclk_i);
        qab_i <= k ? {q[31:5], 5'h3} : 32'h45;
        q_sel_i <= 2'(i % 3);
        x_sel_i <= 3'(i);
        ev_idx_i <= q[4:0] + 5'(i);
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
        qb = {qab_i[31:5], 9'h0};
        sz = 32'h1 << qab_i[4:0];
        chk("q_base", q_store_base_o, qb);
        chk("q_size", q_size_o, sz);
        chk("q_start", q_start_o, qb + 36'(i % 3) * (36'(sz) << 5));
        chk("x_start", x_start_o, qb - 36'(16 * (i + 1)));
        chk("ev_addr", ev_addr_o, ev_base_i + 36'(ev_idx_i) * 36'h8);
      end
    end
    slots  = '{sz - 1, sz, sz - 1, 32'h0, rnd() % (sz - 1)};
    faults = '{CSPM_Q_OK, CSPM_Q_FULL, CSPM_Q_FULL, CSPM_Q_MEMERR, CSPM_Q_OK};
    for (int j = 0; j < 5; j++) begin
      @(posedge mclk_i);
      q_sel_i <= 2'(j % 3);
      q_slot_i <= slots[j];
      q_ctx_zero_i <= (j == 2) || (j == 4);
      q_mem_err_i <= (j == 3);
      repeat (2) @(posedge mclk_i);
      st = qb + 36'(j % 3) * (36'(sz) << 5) + (36'(slots[j]) << 5);
      qop_q.push_back({faults[j], st});
      q_op_i <= 1'b1;
      @(posedge mclk_i);
      q_op_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
    end
    chk("pending", exp_q.size() + qop_q.size(), 0);
    wrap_up();
  end
endmodule : comms_slave_memory_map_tb
`default_nettype wire
